// *** design/qfp_addr_map.v ***
// Program address folding onto the implemented space
`include "qfp_defs.vh"
module qfp_addr_map (
    input  wire [`QFP_IP_W-1:0]  ip_i,
    output wire [`QFP_MEM_AW-1:0] mem_addr_o
);
    // Upper bit dropped so addresses wrap
    assign mem_addr_o = ip_i[`QFP_MEM_AW-1:0];
endmodule

// *** design/qfp_core.v ***
// Instruction sequencing core with four-phase fetch pipeline
//
// Contract
// - Input clock divided by four into four non-overlapping phases per instruction cycle.
// - Instruction pointer increments once per instruction cycle, in phase_one.
// - Fetched word captured at phase_four, held for the next execution cycle.
// - Held instruction decoded and executed across phase_two to phase_four.
// - Operand read in phase_two, destination written in phase_four.
// - Next fetch overlaps current execution, one instruction per cycle.
// - Pointer-changing instructions take two cycles; sequential prefetched word is discarded.
// - Instruction pointer is 13 bits, 8K words of 14 bits.
// - Only 4K words present; higher addresses wrap onto them.
// - Reset starts at 0000h; interrupt entry loads 0004h.
`include "qfp_defs.vh"
module qfp_core (
    input  wire                    clock_i,
    input  wire                    resetn_i,
    input  wire [`QFP_INSN_W-1:0]  prog_data_i,
    input  wire                    branch_i,
    input  wire [`QFP_IP_W-1:0]    branch_target_i,
    input  wire                    irq_i,
    input  wire [`QFP_DATA_W-1:0]  result_i,
    output wire [`QFP_MEM_AW-1:0]  prog_addr_o,
    output wire [3:0]              phase_o,
    output reg  [`QFP_IP_W-1:0]    instruction_pointer_o,
    output reg  [`QFP_INSN_W-1:0]  insn_o,
    output reg                     insn_valid_o,
    output reg                     exec_o,
    output wire                    data_rd_o,
    output wire                    data_wr_o,
    output reg  [`QFP_DATA_W-1:0]  wr_data_o
);
    wire [1:0]              phase;
    reg  [`QFP_IP_W-1:0]    next_ip;
    reg                     pend_redirect;
    reg  [`QFP_IP_W-1:0]    pend_target;

    // Phase clocks
    qfp_phase_gen u_phase (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .phase       (phase),
        .phase_hot_o (phase_o)
    );

    // Fold pointer onto implemented words
    qfp_addr_map u_map (
        .ip_i       (instruction_pointer_o),
        .mem_addr_o (prog_addr_o)
    );

    // Pointer update source
    always @* begin
        next_ip = instruction_pointer_o + `QFP_IP_STEP;
        if (pend_redirect) begin
            next_ip = pend_target;
        end
    end

    // Redirect requests latched during execution, applied at next phase_one
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_redirect <= 1'b0;
            pend_target   <= `QFP_RESET_VEC;
        end else if (phase == `QFP_PH_FOUR && insn_valid_o) begin
            // Flushed slot redirects nothing
            if (irq_i) begin
                pend_redirect <= 1'b1;
                pend_target   <= `QFP_IRQ_VEC;
            end else if (branch_i) begin
                pend_redirect <= 1'b1;
                pend_target   <= branch_target_i;
            end else begin
                pend_redirect <= 1'b0;
            end
        end else if (phase == `QFP_PH_ONE) begin
            pend_redirect <= 1'b0;
        end
    end

    // Pointer register, starts at reset vector
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            instruction_pointer_o <= `QFP_RESET_VEC;
        end else if (phase == `QFP_PH_ONE && exec_o) begin
            instruction_pointer_o <= next_ip;
        end
    end

    // Fetch capture and flush
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            insn_o       <= `QFP_INSN_NOP;
            insn_valid_o <= 1'b0;
            exec_o       <= 1'b0;
        end else begin
            if (phase == `QFP_PH_FOUR) begin
                exec_o <= 1'b1;
                // Capture word fetched this cycle
                if (insn_valid_o && (branch_i || irq_i)) begin
                    insn_o       <= `QFP_INSN_NOP;
                    insn_valid_o <= 1'b0;
                end else begin
                    // Reset-vector word executes too
                    insn_o       <= prog_data_i;
                    insn_valid_o <= 1'b1;
                end
            end
        end
    end

    // Operand read and destination write timing
    assign data_rd_o = insn_valid_o && (phase == `QFP_PH_TWO);
    assign data_wr_o = insn_valid_o && (phase == `QFP_PH_FOUR);

    // Result captured during phase_three for the phase_four write
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_data_o <= {`QFP_DATA_W{1'b0}};
        end else if (phase == `QFP_PH_THREE && insn_valid_o) begin
            wr_data_o <= result_i;
        end
    end
endmodule

// *** design/qfp_defs.vh ***
// Constants for the four-phase fetch pipeline
`ifndef QFP_DEFS_VH
`define QFP_DEFS_VH
`define QFP_IP_W        13
`define QFP_MEM_AW      12
`define QFP_INSN_W      14
`define QFP_DATA_AW     9
`define QFP_DATA_W      8
`define QFP_RESET_VEC   13'h0000
`define QFP_IRQ_VEC     13'h0004
`define QFP_INSN_NOP    14'h0000
`define QFP_PH_ONE      2'h0
`define QFP_PH_TWO      2'h1
`define QFP_PH_THREE    2'h2
`define QFP_PH_FOUR     2'h3
`define QFP_PH_STEP     2'h1
`define QFP_IP_STEP     13'h0001
`endif

// *** design/qfp_phase_gen.v ***
// Four-phase generator dividing the input clock by four
`include "qfp_defs.vh"
module qfp_phase_gen (
    input  wire       clock_i,
    input  wire       resetn_i,
    output reg  [1:0] phase,
    output wire [3:0] phase_hot_o
);
    // Divide by four
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= `QFP_PH_ONE;
        end else begin
            phase <= phase + `QFP_PH_STEP;
        end
    end

    // One-hot, never overlapping phases
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_hot
            localparam [1:0] PH_CODE = g;
            assign phase_hot_o[g] = (phase == PH_CODE);
        end
    endgenerate
endmodule

// *** testbench/qfp_core_assertions.sv ***
// Concurrent checks on the fetch core ports
`include "qfp_defs.vh"
module qfp_core_chk (
    input wire        clock_i, resetn_i, branch_i, irq_i, exec_o, insn_valid_o,
    input wire        data_rd_o, data_wr_o,
    input wire [12:0] branch_target_i, instruction_pointer_o,
    input wire [13:0] prog_data_i, insn_o,
    input wire [11:0] prog_addr_o,
    input wire [7:0]  result_i, wr_data_o,
    input wire [3:0]  phase_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire take_now = phase_o[3] && exec_o && insn_valid_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    phase_hot_a: assert property ($onehot(phase_o)) else $error("phase not one-hot");
    phase_seq_a: assert property (phase_o[0] |=> phase_o[1] ##1 phase_o[2] ##1 phase_o[3]
        ##1 phase_o[0]) else $error("phase order");
    addr_wrap_a: assert property (prog_addr_o == instruction_pointer_o[11:0])
        else $error("address fold");
    rd_slot_a: assert property (data_rd_o |-> phase_o[1] && insn_valid_o)
        else $error("read slot");
    wr_slot_a: assert property (data_wr_o |-> phase_o[3] && insn_valid_o)
        else $error("write slot");
    wr_data_a: assert property (data_wr_o |-> wr_data_o == $past(result_i))
        else $error("write data");
    seq_step_a: assert property (take_now && !branch_i && !irq_i |=> insn_valid_o
        && insn_o == $past(prog_data_i) ##1 instruction_pointer_o == $past(instruction_pointer_o, 2)
        + 13'h1) else $error("sequential step");
    branch_go_a: assert property (take_now && branch_i && !irq_i |=> !insn_valid_o
        ##1 instruction_pointer_o == $past(branch_target_i, 2)) else $error("branch");
    irq_go_a: assert property (take_now && irq_i |=> !insn_valid_o
        ##1 instruction_pointer_o == `QFP_IRQ_VEC) else $error("interrupt vector");
endmodule
bind qfp_core qfp_core_chk qfp_core_chk_inst (.*);

// *** testbench/qfp_prog_mem.sv ***
// Program memory model facing the fetch core
module qfp_prog_mem (
    input  wire [11:0] addr_i,
    output wire [13:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign data_o = ({2'h0, addr_i} * 14'h3) ^ 14'h2a5;
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the fetch core
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 0, resetn_i = 0, branch_i = 0, irq_i = 0, jump, intr;
    logic [12:0] branch_target_i = 0, ip_was;
    logic [7:0]  result_i = 0;
    wire  [13:0] prog_data_i, insn_o;
    wire  [12:0] instruction_pointer_o;
    wire  [11:0] prog_addr_o;
    wire  [7:0]  wr_data_o;
    wire  [3:0]  phase_o;
    wire         exec_o, insn_valid_o, data_rd_o, data_wr_o;
    int          bad_count = 0, tests_run = 0;
    always #2 clock_i = ~clock_i;
    qfp_prog_mem qfp_prog_mem_inst (.addr_i(prog_addr_o), .data_o(prog_data_i));
    qfp_core qfp_core_inst (.*);
    function automatic logic [13:0] word_at(input logic [11:0] a);
        return ({2'h0, a} * 14'h3) ^ 14'h2a5;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hbaae));
        repeat (12) @(posedge clock_i);
        chk(phase_o, 4'h1);
        chk(instruction_pointer_o, 13'h0000);
        #1 resetn_i = 1;
        $display("reset test done");
        repeat (1200) begin
            @(posedge clock_i);
            #1;
            result_i = $urandom;
            if (phase_o !== 4'h8) {branch_i, irq_i} = $urandom;
            else if (insn_valid_o !== 1'b1) {branch_i, irq_i} = 2'h0;
            else begin
                ip_was = instruction_pointer_o;
                jump = ($urandom % 3) == 0;
                intr = ($urandom % 7) == 0;
                branch_target_i = ($urandom % 4 == 0) ? 13'h1fff : 13'($urandom);
                {branch_i, irq_i} = {jump, intr};
                @(posedge clock_i);
                #1;
                chk(insn_valid_o, !(jump || intr));
                chk(insn_o, (jump || intr) ? 14'h0 : word_at(ip_was[11:0]));
                @(posedge clock_i);
                #1;
                chk(instruction_pointer_o, intr ? 13'h0004 : jump ? branch_target_i
                    : ip_was + 13'h1);
            end
        end
        $display("stream test done");
        resetn_i = 0;
        #1 chk(instruction_pointer_o, 13'h0000);
        wrap_up();
    end
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
endmodule
